// File: verif/aqc_checker.sv
module aqc_checker #(
   parameter int NUM_QUADS = 10
) (
   input wire logic                     clk,
   input wire logic                     rst,
   input wire logic                     port_wen,
   input wire logic [7:0]               config_port_address,
   input wire logic                     rtc_sel,
   input wire logic                     rtc_wen,
   input wire logic                     mux_invalid,
   input wire logic                     temp_cfg_invalid,
   input aqc_pkg::aqc_input_ctl_t       volt_ctl [NUM_QUADS],
   input aqc_pkg::aqc_input_ctl_t       temp_ctl [NUM_QUADS],
   input aqc_pkg::aqc_gate_ctl_t        gate_ctl [NUM_QUADS]
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   // Counter space decode and its isolation from quad bytes
   rtc_decode_a: assert property (
      rtc_sel == (config_port_address inside {[8'h40:8'h59]}))
      else $error("counter select wrong");
   rtc_strobe_a: assert property (rtc_wen == (port_wen && rtc_sel))
      else $error("counter strobe wrong");
   rtc_isolate_a: assert property (
      rtc_wen |=> $stable(gate_ctl[0]) && $stable(volt_ctl[0]))
      else $error("counter write touched quad");
   quiet_hold_a: assert property (
      !port_wen |=> $stable(volt_ctl[0]) && $stable(temp_ctl[0]))
      else $error("quad byte changed without write");
   // Field decodes
   gain_link_a: assert property (volt_ctl[0].gain_shift == 5'(volt_ctl[0].range))
      else $error("gain shift wrong");
   cur_table_a: assert property (
      gate_ctl[0].cur_ua == (gate_ctl[0].cur_code == 2'h0 ? 6'h01 :
      gate_ctl[0].cur_code == 2'h1 ? 6'h03 : gate_ctl[0].cur_code == 2'h2 ? 6'h0a : 6'h1e))
      else $error("gate current wrong");
   mux_flag_a: assert property (volt_ctl[0].mux == aqc_pkg::AQC_MUX_BAD |-> mux_invalid)
      else $error("bad mux not flagged");
   temp_flag_a: assert property (!(temp_ctl[0].range inside {3'h0, 3'h2}) |-> temp_cfg_invalid)
      else $error("bad temp range not flagged");
   temp_pos_a: assert property (temp_ctl[0].negative == 1'b0)
      else $error("temp polarity not positive");
endmodule
bind aqc_quad_cfg aqc_checker #(.NUM_QUADS(NUM_QUADS)) aqc_checker_i (.*);

// File: verif/aqc_fabric_model.sv
module aqc_fabric_model (
   input wire logic       clk,
   output logic           port_wen,
   output logic           quad_write_enable,
   output logic           byte_lane_enable,
   output logic           internal_oscillator_input,
   output logic     [7:0] config_port_address,
   output logic     [7:0] port_wdata,
   input wire logic [7:0] port_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle port
   initial {port_wen, quad_write_enable, byte_lane_enable, internal_oscillator_input} = 4'h0;
   initial {config_port_address, port_wdata} = 16'h0;
   // One write; full low keeps enables and oscillator low, port_wen still pulses
   task automatic wr(input logic [7:0] a, d, input logic full);
      @(posedge clk);
      config_port_address <= a;
      port_wdata <= d;
      port_wen <= 1'b1;
      quad_write_enable <= full;
      byte_lane_enable <= full;
      @(posedge clk);
      internal_oscillator_input <= full;
      @(posedge clk);
      {port_wen, quad_write_enable, byte_lane_enable, internal_oscillator_input} <= 4'h0;
      port_wdata <= ~d; // Released data never shows stale value
   endtask
   // Read with one cycle of latency
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      config_port_address <= a;
      @(posedge clk);
      #1 d = port_rdata;
   endtask
endmodule

// File: verif/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst;
   int fails = 0;
   int checks = 0;
   logic port_wen, quad_write_enable, byte_lane_enable, internal_oscillator_input;
   logic [7:0] config_port_address, port_wdata, port_rdata, rb, d;
   logic rtc_sel, rtc_wen, mux_invalid, temp_cfg_invalid;
   logic [9:0] curr_mon_on;
   aqc_pkg::aqc_input_ctl_t volt_ctl [10], curr_ctl [10], temp_ctl [10];
   aqc_pkg::aqc_gate_ctl_t gate_ctl [10];
   logic [7:0] exp_b [40] = '{default: 8'h00};
   logic [7:0] off_map [5] = '{8'h00, 8'h29, 8'h3f, 8'h5a, 8'hff};
   aqc_quad_cfg #(.NUM_QUADS(10)) aqc_quad_cfg_i (.*);
   aqc_fabric_model aqc_fabric_model_i (.*);
   ////////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   always #2 clk = ~clk;
   initial begin
      #100us;
      fails++;
      test_done();
   end
   // Compare and verdict helpers
   task automatic chk(input logic [15:0] g, e);
      checks++;
      if (g !== e) begin
         fails++;
         $display("Error t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic test_done;
      if (fails == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Expected decodes of input and gate bytes
   function automatic logic [12:0] din(input logic [7:0] b);
      return {b[7:3], b[2:0], 2'h0, b[2:0]};
   endfunction
   function automatic logic [10:0] gdec(input logic [7:0] b);
      logic [5:0] ua [4] = '{6'h01, 6'h03, 6'h0a, 6'h1e};
      return {b[7:6], b[3:2], ua[b[3:2]], b[0]};
   endfunction
   // Read back every byte and every decoded output
   task automatic vchk;
      logic mi;
      mi = 1'b0;
      for (int a = 1; a <= 40; a++) begin
         aqc_fabric_model_i.rd(8'(a), rb);
         chk(rb, exp_b[a-1]);
      end
      for (int q = 0; q < 10; q++) begin
         chk(volt_ctl[q], din(exp_b[4*q]));
         chk(curr_ctl[q], din(exp_b[4*q+1]));
         chk(temp_ctl[q], din(exp_b[4*q+3]));
         chk(gate_ctl[q], gdec(exp_b[4*q+2]));
         chk(curr_mon_on[q], exp_b[4*q][4]);
         mi |= &exp_b[4*q][4:3] | &exp_b[4*q+1][4:3] | &exp_b[4*q+3][4:3];
      end
      chk(mux_invalid, mi);
      chk(temp_cfg_invalid, 1'b0);
   endtask
   // Main sequence
   initial begin
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      vchk();
      for (int a = 1; a <= 40; a++) begin
         d = 8'(a * 29);
         if (a % 4 == 0) d = d & 8'hba; // Temperature code 000 or 010
         exp_b[a-1] = d;
         aqc_fabric_model_i.wr(8'(a), d, 1'b1);
      end
      aqc_fabric_model_i.wr(8'h06, 8'h5a, 1'b1);
      exp_b[5] = 8'h5a;
      for (int i = 0; i < 5; i++) aqc_fabric_model_i.wr(off_map[i], 8'hff, 1'b1);
      aqc_fabric_model_i.wr(8'h07, 8'hff, 1'b0);
      aqc_fabric_model_i.wr(8'h40, 8'hff, 1'b0);
      aqc_fabric_model_i.wr(8'h59, 8'hff, 1'b1);
      @(negedge clk);
      chk(rtc_sel, 1'b1);
      chk(rtc_wen, 1'b0);
      vchk();
      aqc_fabric_model_i.wr(8'h04, 8'h03, 1'b1);
      @(posedge clk);
      chk(temp_cfg_invalid, 1'b1);
      test_done();
   end
endmodule

// File: verilog/aqc_pkg.sv
package aqc_pkg;
   // Prescaler range code, gain doubles per step
   typedef enum logic [2:0] {
      AQC_RANGE_16V   = 3'h0,
      AQC_RANGE_8V    = 3'h1,
      AQC_RANGE_4V    = 3'h2,
      AQC_RANGE_2V    = 3'h3,
      AQC_RANGE_1V    = 3'h4,
      AQC_RANGE_0V5   = 3'h5,
      AQC_RANGE_0V25  = 3'h6,
      AQC_RANGE_0V125 = 3'h7
   } aqc_range_t;
   // Analog mux routing
   typedef enum logic [1:0] {
      AQC_MUX_PRESC  = 2'h0,
      AQC_MUX_DIRECT = 2'h1,
      AQC_MUX_MON    = 2'h2,
      AQC_MUX_BAD    = 2'h3
   } aqc_mux_t;
   // Decoded analog input channel controls
   typedef struct packed {
      logic       amp_on;
      logic       negative;
      logic       direct_on;
      aqc_mux_t   mux;
      aqc_range_t range;
      logic [4:0] gain_shift;
   } aqc_input_ctl_t;
   // Decoded gate driver controls
   typedef struct packed {
      logic       high_drive;
      logic       negative;
      logic [1:0] cur_code;
      logic [5:0] cur_ua;
      logic       temp_monitor_power;
   } aqc_gate_ctl_t;
   // Configuration port write strobe group
   typedef struct packed {
      logic       wen;
      logic [7:0] addr;
      logic [7:0] wdata;
   } aqc_port_req_t;
endpackage

// File: verilog/aqc_quad_cfg.sv
`include "aqc_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module aqc_quad_cfg #(
   parameter int NUM_QUADS = 10
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   // Configuration port
   input  wire logic                   port_wen,
   input  wire logic                   quad_write_enable,
   input  wire logic                   byte_lane_enable,
   input  wire logic                   internal_oscillator_input,
   input  wire logic [7:0]             config_port_address,
   input  wire logic [7:0]             port_wdata,
   output logic      [7:0]             port_rdata,
   // Counter space pass-through
   output logic                        rtc_sel,
   output logic                        rtc_wen,
   // Configuration error flags
   output logic                        mux_invalid,
   output logic                        temp_cfg_invalid,
   // Decoded quad controls
   output aqc_pkg::aqc_input_ctl_t     volt_ctl     [NUM_QUADS],
   output aqc_pkg::aqc_input_ctl_t     curr_ctl     [NUM_QUADS],
   output aqc_pkg::aqc_input_ctl_t     temp_ctl     [NUM_QUADS],
   output logic      [NUM_QUADS-1:0]   curr_mon_on,
   output aqc_pkg::aqc_gate_ctl_t      gate_ctl     [NUM_QUADS]
);

   // Four bytes per quad in flat storage
   localparam int NBYTES = 4 * NUM_QUADS;

   // Storage, write path and readback
   logic [7:0]           cfg_r [NBYTES];
   logic                 osc_d_r;
   logic                 osc_rise;
   logic                 quad_hit;
   logic [7:0]           idx;
   logic                 quad_wr;
   logic [NBYTES-1:0]    byte_we;
   logic [7:0]           rdata_nxt;

   // Per-quad byte views
   logic [7:0]           volt_b [NUM_QUADS];
   logic [7:0]           curr_b [NUM_QUADS];
   logic [7:0]           gate_b [NUM_QUADS];
   logic [7:0]           temp_b [NUM_QUADS];

   // Per-quad error flags
   logic [NUM_QUADS-1:0] mux_bad_q;
   logic [NUM_QUADS-1:0] temp_bad_q;

   ////////////////////////////////////////////////////////////////////////////
   // Decode: quad byte index from address, 1-based
   function automatic logic is_quad(input logic [7:0] a);
      is_quad = (a >= `AQC_QUAD_FIRST) && (a < `AQC_QUAD_FIRST + 8'(NBYTES));
   endfunction

   function automatic logic is_rtc(input logic [7:0] a);
      is_rtc = (a >= `AQC_RTC_FIRST) && (a <= `AQC_RTC_LAST);
   endfunction

   // Lane of a flat byte slot within its quad
   function automatic int lane_of(input int i);
      lane_of = i % 4;
   endfunction

   // Flat storage index of one lane of one quad
   function automatic int byte_at(input int q, input logic [1:0] lane);
      byte_at = 4 * q + int'(lane);
   endfunction

   // Address hits one flat byte slot
   function automatic logic hit_at(input logic [7:0] a, input int i);
      hit_at = is_quad(a) && ((a - `AQC_QUAD_FIRST) == 8'(i));
   endfunction

   // Prescaler code field of an input byte
   function automatic aqc_pkg::aqc_range_t range_of(input logic [7:0] b);
      range_of = aqc_pkg::aqc_range_t'(b[`AQC_IN_PRESC_LSB +: 3]);
   endfunction

   // Mux field of an input byte
   function automatic aqc_pkg::aqc_mux_t mux_of(input logic [7:0] b);
      mux_of = aqc_pkg::aqc_mux_t'(b[`AQC_IN_MUX_LSB +: 2]);
   endfunction

   // Prescaler gain as a power-of-two step above the 16 V range
   function automatic logic [4:0] gain_of(input logic [2:0] code);
      logic [4:0] g;
      g = 5'h00;
      unique case (code)
         3'h0: g = 5'h00;  // Gain 0.15625
         3'h1: g = 5'h01;
         3'h2: g = 5'h02;
         3'h3: g = 5'h03;
         3'h4: g = 5'h04;
         3'h5: g = 5'h05;
         3'h6: g = 5'h06;
         3'h7: g = 5'h07;  // Gain 20.0
      endcase
      gain_of = g;
   endfunction

   // Mux code with no routing behind it
   function automatic logic mux_bad(input aqc_pkg::aqc_mux_t m);
      mux_bad = (m == aqc_pkg::AQC_MUX_BAD);
   endfunction

   // Temperature input works only on the 16 V and 4 V steps
   function automatic logic temp_range_bad(input aqc_pkg::aqc_range_t r);
      temp_range_bad = (r != aqc_pkg::AQC_RANGE_16V) && (r != aqc_pkg::AQC_RANGE_4V);
   endfunction

   // Input byte decode into channel controls
   function automatic aqc_pkg::aqc_input_ctl_t dec_in(input logic [7:0] b);
      aqc_pkg::aqc_input_ctl_t c;
      c.range      = range_of(b);
      c.gain_shift = gain_of(b[`AQC_IN_PRESC_LSB +: 3]);
      c.mux        = mux_of(b);
      c.direct_on  = b[`AQC_IN_DIRECT_BIT];
      c.negative   = b[`AQC_IN_POL_BIT];
      c.amp_on     = b[`AQC_IN_AMP_BIT];
      dec_in = c;
   endfunction

   // Low-drive current in microamps
   function automatic logic [5:0] gd_ua(input logic [1:0] code);
      logic [5:0] u;
      u = 6'h01;
      unique case (code)
         2'h0: u = 6'h01;
         2'h1: u = 6'h03;
         2'h2: u = 6'h0a;
         2'h3: u = 6'h1e;
      endcase
      gd_ua = u;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Quad write timing: write on oscillator rising edge with both enables
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         osc_d_r <= 1'b0;
      end else begin
         osc_d_r <= internal_oscillator_input;
      end
   end

   // Strobe edge and address decode
   assign osc_rise = internal_oscillator_input & ~osc_d_r;
   assign quad_hit = is_quad(config_port_address);
   assign idx      = config_port_address - `AQC_QUAD_FIRST;

   // Quad write qualifier; counter space never reaches it
   assign quad_wr  = port_wen & quad_hit & quad_write_enable & byte_lane_enable & osc_rise;

   // One-hot byte strobe, only the addressed byte may load
   always_comb begin
      byte_we = '0;
      for (int i = 0; i < NBYTES; i++) begin
         if (quad_wr && hit_at(config_port_address, i)) begin
            byte_we[i] = 1'b1;
         end
      end
   end

   // Configuration byte storage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NBYTES; i++) begin
            // Gate lane has its own default, inputs share one
            if (lane_of(i) == int'(`AQC_BYTE_GATE)) begin
               cfg_r[i] <= `AQC_GD_RESET;
            end else begin
               cfg_r[i] <= `AQC_IN_RESET;
            end
         end
      end else begin
         for (int i = 0; i < NBYTES; i++) begin
            if (byte_we[i]) begin
               cfg_r[i] <= port_wdata;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // RTC space passes straight through, no timing generator
   assign rtc_sel = is_rtc(config_port_address);
   assign rtc_wen = port_wen & rtc_sel;

   // Readback source: addressed quad byte, zero elsewhere
   always_comb begin
      rdata_nxt = 8'h00;
      for (int i = 0; i < NBYTES; i++) begin
         if (hit_at(config_port_address, i)) begin
            rdata_nxt = cfg_r[i];
         end
      end
   end

   // Readback register, one cycle behind the address
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         port_rdata <= 8'h00;
      end else begin
         port_rdata <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Byte views: the four lanes of each quad
   always_comb begin
      for (int q = 0; q < NUM_QUADS; q++) begin
         volt_b[q] = cfg_r[byte_at(q, `AQC_BYTE_VOLT)];
         curr_b[q] = cfg_r[byte_at(q, `AQC_BYTE_CURR)];
         gate_b[q] = cfg_r[byte_at(q, `AQC_BYTE_GATE)];
         temp_b[q] = cfg_r[byte_at(q, `AQC_BYTE_TEMP)];
      end
   end

   // Voltage input controls
   always_comb begin
      for (int q = 0; q < NUM_QUADS; q++) begin
         volt_ctl[q] = dec_in(volt_b[q]);
      end
   end

   // Current input controls
   always_comb begin
      for (int q = 0; q < NUM_QUADS; q++) begin
         curr_ctl[q] = dec_in(curr_b[q]);
      end
   end

   // Current monitor switch lives in the voltage byte
   always_comb begin
      for (int q = 0; q < NUM_QUADS; q++) begin
         curr_mon_on[q] = volt_b[q][`AQC_IN_CMON_BIT];
      end
   end

   // Temperature input controls, polarity pinned positive
   always_comb begin
      for (int q = 0; q < NUM_QUADS; q++) begin
         temp_ctl[q]          = dec_in(temp_b[q]);
         temp_ctl[q].negative = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Gate driver controls; spare bits 1, 4 and 5 have no effect
   always_comb begin
      for (int q = 0; q < NUM_QUADS; q++) begin
         gate_ctl[q].temp_monitor_power = gate_b[q][`AQC_GD_TMON_BIT];
         gate_ctl[q].cur_code           = gate_b[q][`AQC_GD_CUR_LSB +: 2];
         gate_ctl[q].cur_ua             = gd_ua(gate_b[q][`AQC_GD_CUR_LSB +: 2]);
         gate_ctl[q].negative           = gate_b[q][`AQC_GD_POL_BIT];
         gate_ctl[q].high_drive         = gate_b[q][`AQC_GD_HIGH_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-quad mux code check on all three inputs
   always_comb begin
      for (int q = 0; q < NUM_QUADS; q++) begin
         mux_bad_q[q] = mux_bad(volt_ctl[q].mux) | mux_bad(curr_ctl[q].mux)
                        | mux_bad(temp_ctl[q].mux);
      end
   end

   // Per-quad temperature range check
   always_comb begin
      for (int q = 0; q < NUM_QUADS; q++) begin
         temp_bad_q[q] = temp_range_bad(temp_ctl[q].range);
      end
   end

   // Any quad with a bad mux code raises the shared flag
   assign mux_invalid      = |mux_bad_q;

   // Any quad with a bad temperature range raises its flag
   assign temp_cfg_invalid = |temp_bad_q;

endmodule

// File: verilog/aqc_regs.svh
`ifndef AQC_REGS_SVH
`define AQC_REGS_SVH
// Address map of the configuration port
`define AQC_QUAD_FIRST     8'h01
`define AQC_QUAD_LAST      8'h28
`define AQC_RTC_FIRST      8'h40
`define AQC_RTC_LAST       8'h59
// Byte index within a quad
`define AQC_BYTE_VOLT      2'h0
`define AQC_BYTE_CURR      2'h1
`define AQC_BYTE_GATE      2'h2
`define AQC_BYTE_TEMP      2'h3
// Input byte fields
`define AQC_IN_PRESC_LSB   0
`define AQC_IN_MUX_LSB     3
`define AQC_IN_CMON_BIT    4
`define AQC_IN_DIRECT_BIT  5
`define AQC_IN_POL_BIT     6
`define AQC_IN_AMP_BIT     7
// Gate byte fields
`define AQC_GD_TMON_BIT    0
`define AQC_GD_CUR_LSB     2
`define AQC_GD_POL_BIT     6
`define AQC_GD_HIGH_BIT    7
// Power-up defaults: highest range, prescaler mux, all off, positive
`define AQC_IN_RESET       8'h00
`define AQC_GD_RESET       8'h00
`define AQC_GD_SPARE_MASK  8'h32
`endif
